/* File: stb_pkg.sv */
// Package of constants for the step sequencer broadcast trigger enable block
`default_nettype none
package stb_pkg;
	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] BTE_OFFSET = 8'h00;
	localparam logic [7:0] CTRL_OFFSET = 8'h04;
	localparam logic [7:0] STAT_OFFSET = 8'h08;
	// Field positions in the broadcast trigger enable register
	localparam int COMPARE1_TRIGGER_BIT = 0;
	localparam int COMPARE2_TRIGGER_BIT = 1;
	localparam int COMPARE3_TRIGGER_BIT = 2;
	localparam int COMPARE4_TRIGGER_BIT = 3;
	localparam int COMPARE1_CLOCK_BIT = 4;
	// Field positions in the control register
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	// Reset values
	localparam logic [15:0] BTE_RESET = 16'h0000;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// Control step command opcode and broadcast option code
	localparam logic [3:0] CTRL_CMD_OPCODE = 4'h1;
	localparam logic [3:0] BROADCAST_OPTION = 4'hf;
	// AHB transfer type for a started transfer
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
`default_nettype wire

/* File: stb_broadcast_trigger.sv */
// Broadcast trigger enable register and strobe generator for the step sequencer
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`default_nettype none

// Functional notes
// - Bit 4 gates clock pulse to compare unit 1
// - Bit 3 gates trigger to compare unit 4
// - Bit 2 gates trigger to compare unit 3
// - Bit 1 gates trigger to compare unit 2
// - Bit 0 gates trigger to compare unit 1
// - Enable register writes ignored while enabled and started
// - Only broadcast control command uses these bits
module stb_broadcast_trigger
	import stb_pkg::*;
#(
	parameter int UNITS = 4 // Output compare units served
) (
	input wire logic clk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Step command executing this cycle, with its opcode and option
	input wire logic cmdExec,
	input wire logic [3:0] cmdOpcode,
	input wire logic [3:0] cmdOption,
	// Strobes toward the output compare units
	output logic [UNITS-1:0] compareTrigger,
	output logic compare1Clock
);

	// Elaboration check: the strobe map is fixed to four units, so any
	// other count would leave strobes unmapped or read past the field
	generate
		if (UNITS != 4) begin : g_bad_units
			$error("stb_broadcast_trigger serves exactly four compare units");
		end
	endgenerate

	logic [15:0] bteReg_r; // Broadcast trigger enable register
	logic [1:0] ctrlReg_r; // Module enable and start flag
	logic wrPend_r; // Data phase of a write is due
	logic [7:0] addrPend_r; // Address captured in the address phase
	logic frozen; // Register locked while sequencing
	logic isBroadcast; // Broadcast control command executes now
	logic [31:0] rdData;
	logic [15:0] sentCount_r; // Broadcasts seen, a status counter

	assign frozen = ctrlReg_r[CTRL_ENABLE_BIT] & ctrlReg_r[CTRL_START_BIT];
	// only the broadcast control command counts
	assign isBroadcast = cmdExec && cmdOpcode == CTRL_CMD_OPCODE
		&& cmdOption == BROADCAST_OPTION;

	// Capture write address phase; the slave never waits, so hreadyout is low only in the first cycle out of reset and stays high after it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend_r <= 1'b0;
			addrPend_r <= 8'h00;
		end else if (hready) begin
			wrPend_r <= hsel && hwrite && htrans == HTRANS_NONSEQ;
			addrPend_r <= haddr;
		end
	end

	// Broadcast enable register, written in the data phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bteReg_r <= BTE_RESET;
		end else if (wrPend_r && addrPend_r == BTE_OFFSET && !frozen) begin
			bteReg_r <= hwdata[15:0];
		end
	end

	// Control register, always writable so software can stop the sequence
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlReg_r <= CTRL_RESET;
		end else if (wrPend_r && addrPend_r == CTRL_OFFSET) begin
			ctrlReg_r <= hwdata[1:0];
		end
	end

	// Count executed broadcasts so software can see activity
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sentCount_r <= 16'h0000;
		end else if (isBroadcast) begin
			sentCount_r <= sentCount_r + 16'h0001;
		end
	end

	// Read mux, decoded from the live address phase; unmapped reads give zero
	always_comb begin
		rdData = 32'h0000_0000;
		unique case (haddr)
			BTE_OFFSET: rdData = {16'h0000, bteReg_r};
			CTRL_OFFSET: rdData = {30'h0, ctrlReg_r};
			STAT_OFFSET: rdData = {15'h0, frozen, sentCount_r};
			default: rdData = 32'h0000_0000;
		endcase
	end

	// Read data registered at the address phase, standing in the data phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && !hwrite && htrans == HTRANS_NONSEQ) begin
			hrdata <= rdData;
		end
	end

	// Zero wait states and always OKAY
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Trigger strobes, one per compare unit, bit i of the register
	// registered single-cycle strobes, all in one cycle
	genvar i;
	generate
		for (i = 0; i < UNITS; i++) begin : g_trig
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					compareTrigger[i] <= 1'b0;
				end else begin
					compareTrigger[i] <= isBroadcast & bteReg_r[COMPARE1_TRIGGER_BIT + i];
				end
			end
		end
	endgenerate

	// clock pulse to compare unit 1
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			compare1Clock <= 1'b0;
		end else begin
			compare1Clock <= isBroadcast & bteReg_r[COMPARE1_CLOCK_BIT];
		end
	end

	// Assertions
	// All checks run on the one system clock and sleep during reset.
	// Strobes are registered, so every strobe check looks one cycle
	// after the command that caused it.
	// clock pulse follows enable
	a_clock_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		compare1Clock == $past(isBroadcast & bteReg_r[COMPARE1_CLOCK_BIT]))
		else $error("compare1 clock pulse mismatch");
	a_trig_unit4: assert property (@(posedge clk) disable iff (sys_rst)
		$past(isBroadcast) |-> compareTrigger[3] == $past(bteReg_r[3]))
		else $error("compare4 trigger mismatch");
	a_trig_unit3: assert property (@(posedge clk) disable iff (sys_rst)
		$past(isBroadcast) |-> compareTrigger[2] == $past(bteReg_r[2]))
		else $error("compare3 trigger mismatch");
	a_trig_unit2: assert property (@(posedge clk) disable iff (sys_rst)
		$past(isBroadcast) |-> compareTrigger[1] == $past(bteReg_r[1]))
		else $error("compare2 trigger mismatch");
	a_trig_unit1: assert property (@(posedge clk) disable iff (sys_rst)
		$past(isBroadcast) |-> compareTrigger[0] == $past(bteReg_r[0]))
		else $error("compare1 trigger mismatch");
	a_frozen_hold: assert property (@(posedge clk) disable iff (sys_rst)
		frozen |=> $stable(bteReg_r))
		else $error("enable register changed while frozen");
	a_other_cmd_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!isBroadcast |=> compareTrigger == '0 && !compare1Clock)
		else $error("strobe without broadcast command");
	sequence s_single_pulse;
		compareTrigger[0] ##1 !compareTrigger[0];
	endsequence
	// A strobe stays one cycle unless another broadcast follows at once
	a_pulse_width: assert property (@(posedge clk) disable iff (sys_rst)
		compareTrigger[0] && !isBroadcast |-> s_single_pulse)
		else $error("trigger pulse longer than one cycle");
	a_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
		wrPend_r && addrPend_r == BTE_OFFSET && !frozen |=> bteReg_r == $past(hwdata[15:0]))
		else $error("register write lost");

	// Bus side: the slave answers with no wait state and never an error,
	// so a master that waits on hready cannot hang on this block
	a_resp_okay: assert property (@(posedge clk) disable iff (sys_rst)
		hresp == 1'b0)
		else $error("error response on the bus");
	// Ready is low only in the first cycle out of reset
	a_ready_high: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) |-> hreadyout)
		else $error("slave stalled the bus");

	// Read data is the register addressed in the address phase, and it
	// holds until the next read so a slow master still sees it
	a_read_data: assert property (@(posedge clk) disable iff (sys_rst)
		hready && hsel && !hwrite && htrans == HTRANS_NONSEQ |=> hrdata == $past(rdData))
		else $error("read data does not match register");
	a_read_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(hready && hsel && !hwrite && htrans == HTRANS_NONSEQ) |=> $stable(hrdata))
		else $error("read data changed without a read");

	// Control register: written only by its own data phase, never frozen
	a_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
		wrPend_r && addrPend_r == CTRL_OFFSET |=> ctrlReg_r == $past(hwdata[1:0]))
		else $error("control write lost");
	a_ctrl_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(wrPend_r && addrPend_r == CTRL_OFFSET) |=> $stable(ctrlReg_r))
		else $error("control register changed without a write");

	// other addresses never touch the enable register
	a_bte_other_addr: assert property (@(posedge clk) disable iff (sys_rst)
		wrPend_r && addrPend_r != BTE_OFFSET |=> $stable(bteReg_r))
		else $error("enable register changed by another address");
	// an idle bus leaves the enable register alone
	a_bte_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!wrPend_r |=> $stable(bteReg_r))
		else $error("enable register changed without a write");
	// a write that meets the lock is dropped at that very edge
	a_frozen_drop: assert property (@(posedge clk) disable iff (sys_rst)
		wrPend_r && addrPend_r == BTE_OFFSET && frozen |=> $stable(bteReg_r))
		else $error("write accepted while frozen");

	// Status counter: one step per broadcast, wrapping at the top so a
	// long run never saturates and software can subtract two reads
	a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
		isBroadcast |=> sentCount_r == $past(sentCount_r) + 16'h0001)
		else $error("broadcast count did not step");
	a_count_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!isBroadcast |=> $stable(sentCount_r))
		else $error("broadcast count moved without a broadcast");

	// named steps of one broadcast, used by the checks below
	sequence s_broadcast_now;
		isBroadcast;
	endsequence
	sequence s_one_cycle(sig);
		sig ##1 !sig;
	endsequence
	// with all five fields set, every strobe rises together one cycle after the command
	a_all_together: assert property (@(posedge clk) disable iff (sys_rst)
		s_broadcast_now ##0 (&bteReg_r[COMPARE1_CLOCK_BIT:COMPARE1_TRIGGER_BIT])
		|=> compareTrigger == 4'hf && compare1Clock)
		else $error("enabled strobes not in one cycle");
	// every strobe is a single-cycle pulse without a following broadcast
	a_width_unit2: assert property (@(posedge clk) disable iff (sys_rst)
		compareTrigger[1] && !isBroadcast |-> s_one_cycle(compareTrigger[1]))
		else $error("compare2 trigger longer than one cycle");
	a_width_unit3: assert property (@(posedge clk) disable iff (sys_rst)
		compareTrigger[2] && !isBroadcast |-> s_one_cycle(compareTrigger[2]))
		else $error("compare3 trigger longer than one cycle");
	a_width_unit4: assert property (@(posedge clk) disable iff (sys_rst)
		compareTrigger[3] && !isBroadcast |-> s_one_cycle(compareTrigger[3]))
		else $error("compare4 trigger longer than one cycle");
	a_width_clock: assert property (@(posedge clk) disable iff (sys_rst)
		compare1Clock && !isBroadcast |-> s_one_cycle(compare1Clock))
		else $error("compare1 clock pulse longer than one cycle");

	// a control command with another option must stay silent
	a_other_option: assert property (@(posedge clk) disable iff (sys_rst)
		cmdExec && cmdOpcode == CTRL_CMD_OPCODE && cmdOption != BROADCAST_OPTION
		|=> compareTrigger == '0 && !compare1Clock)
		else $error("strobe from another control option");
	// the broadcast option under another opcode must stay silent
	a_other_opcode: assert property (@(posedge clk) disable iff (sys_rst)
		cmdExec && cmdOpcode != CTRL_CMD_OPCODE |=> compareTrigger == '0 && !compare1Clock)
		else $error("strobe from another opcode");

	// A cleared field keeps its strobe quiet even when the command runs;
	// these catch a strobe wired to the wrong field
	a_clock_off: assert property (@(posedge clk) disable iff (sys_rst)
		isBroadcast && !bteReg_r[COMPARE1_CLOCK_BIT] |=> !compare1Clock)
		else $error("clock pulse with its field clear");
	a_trig4_off: assert property (@(posedge clk) disable iff (sys_rst)
		isBroadcast && !bteReg_r[COMPARE4_TRIGGER_BIT] |=> !compareTrigger[3])
		else $error("compare4 trigger with its field clear");
	a_trig3_off: assert property (@(posedge clk) disable iff (sys_rst)
		isBroadcast && !bteReg_r[COMPARE3_TRIGGER_BIT] |=> !compareTrigger[2])
		else $error("compare3 trigger with its field clear");
	a_trig2_off: assert property (@(posedge clk) disable iff (sys_rst)
		isBroadcast && !bteReg_r[COMPARE2_TRIGGER_BIT] |=> !compareTrigger[1])
		else $error("compare2 trigger with its field clear");
	a_trig1_off: assert property (@(posedge clk) disable iff (sys_rst)
		isBroadcast && !bteReg_r[COMPARE1_TRIGGER_BIT] |=> !compareTrigger[0])
		else $error("compare1 trigger with its field clear");
	// Limitation: bits above the clock field are stored and read back but
	// drive nothing here; they belong to units outside this block

endmodule
`default_nettype wire

/* File: stb_oc_model.sv */
// Model of the output compare units that count strobe cycles
`default_nettype none
module stb_oc_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] trig,
	input wire logic clk1,
	output logic [7:0] pulses
);
	timeunit 1ns;
	timeprecision 1ps;
	// A strobe held two cycles counts twice, so stretched pulses show up
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulses <= 8'h00;
		end else if (|{trig, clk1}) begin
			pulses <= pulses + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* File: tb_step_seq_broadcast_trigger_enable.sv */
// Self-checking bench for the broadcast trigger enable block
`default_nettype none
module tb_step_seq_broadcast_trigger_enable;
	timeunit 1ns;
	timeprecision 1ps;
	import stb_pkg::*;
	logic clk = 1'b0, sysRst = 1'b1, hsel = 1'b1, hwrite = 1'b0, cmdExec = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rdv;
	logic [3:0] cmdOpcode = 4'h0, cmdOption = 4'h0, compareTrigger;
	logic hreadyout, hresp, compare1Clock;
	logic [7:0] pulses;
	int mismatches = 0, checksDone = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Single slave, so its ready is the bus ready
	stb_broadcast_trigger dut (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmdExec(cmdExec),
		.cmdOpcode(cmdOpcode), .cmdOption(cmdOption), .compareTrigger(compareTrigger),
		.compare1Clock(compare1Clock));
	stb_oc_model partner (.clk(clk), .sys_rst(sysRst), .trig(compareTrigger),
		.clk1(compare1Clock), .pulses(pulses));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Bounded wait for ready sampled at a rising edge
	task automatic waitRdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			tally_and_finish();
		end
	endtask
	// One AHB single transfer; read data lands in rdv
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		waitRdy();
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		rdv = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	// Step command, then strobes seen for exactly one cycle
	task automatic bcast(input logic [3:0] op, input logic [3:0] opt, input logic [4:0] e);
		cmdExec <= 1'b1;
		cmdOpcode <= op;
		cmdOption <= opt;
		@(posedge clk);
		cmdExec <= 1'b0;
		@(negedge clk);
		chk("strobes", {27'h0, e}, {27'h0, compare1Clock, compareTrigger});
		@(negedge clk);
		chk("strobes off", 32'h0, {27'h0, compare1Clock, compareTrigger});
		@(posedge clk);
	endtask
	task automatic tReset;
		xfer(1'b0, BTE_OFFSET, 32'h0);
		chk("bte reset", {16'h0, BTE_RESET}, rdv);
		xfer(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h0, rdv);
		$display("test reset done");
	endtask
	task automatic tBits;
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, BTE_OFFSET, 32'h1 << i);
			bcast(CTRL_CMD_OPCODE, BROADCAST_OPTION, 5'h01 << i);
		end
		xfer(1'b1, BTE_OFFSET, 32'h1f);
		bcast(CTRL_CMD_OPCODE, BROADCAST_OPTION, 5'h1f);
		$display("test bits done");
	endtask
	// Other commands must stay silent even with all five enable bits set
	task automatic tOther;
		bcast(4'h0, BROADCAST_OPTION, 5'h00);
		bcast(CTRL_CMD_OPCODE, 4'he, 5'h00);
		$display("test other done");
	endtask
	// Enable alone must not freeze; enable with start must
	task automatic tFreeze;
		xfer(1'b1, CTRL_OFFSET, 32'h1);
		xfer(1'b1, BTE_OFFSET, 32'h5);
		xfer(1'b0, BTE_OFFSET, 32'h0);
		chk("bte enable only", 32'h5, rdv);
		xfer(1'b1, CTRL_OFFSET, 32'h3);
		xfer(1'b1, BTE_OFFSET, 32'h1a);
		xfer(1'b0, BTE_OFFSET, 32'h0);
		chk("bte frozen", 32'h5, rdv);
		xfer(1'b0, STAT_OFFSET, 32'h0);
		chk("status frozen", 32'h0001_0006, rdv);
		bcast(CTRL_CMD_OPCODE, BROADCAST_OPTION, 5'h05);
		xfer(1'b1, CTRL_OFFSET, 32'h0);
		xfer(1'b1, BTE_OFFSET, 32'h1a);
		xfer(1'b0, BTE_OFFSET, 32'h0);
		chk("bte thawed", 32'h1a, rdv);
		$display("test freeze done");
	endtask
	// Reset in mid-run clears the register and the count
	task automatic tResetMid;
		xfer(1'b1, BTE_OFFSET, 32'h1f);
		sysRst <= 1'b1;
		repeat (2) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		xfer(1'b0, BTE_OFFSET, 32'h0);
		chk("bte after reset", {16'h0, BTE_RESET}, rdv);
		xfer(1'b0, STAT_OFFSET, 32'h0);
		chk("status after reset", 32'h0, rdv);
		bcast(CTRL_CMD_OPCODE, BROADCAST_OPTION, 5'h00);
		$display("test mid reset done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		tReset();
		tBits();
		tOther();
		tFreeze();
		chk("pulse count", 32'h7, {24'h0, pulses});
		tResetMid();
		tally_and_finish();
	end
endmodule
`default_nettype wire
